// ---- logic/dma_bus_tenure_control.sv ----
// dma channel bus tenure, vme beat pacing and pci burst pacing
// Contract
// - count dma bytes per vme tenure, end tenure when the byte limit is reached.
// - after a tenure expiry, wait the back-off time before requesting the vme bus.
// - even under release-on-request with no rivals, pause when the byte counter expires.
// - retry coupled pci accesses while dma owns vme; retry posted ones when queue full.
// - vme beats of 8 to 64 bits, single-cycle and block modes.
// - vme beat time is the same for every data width except 64-bit block writes, which pace as multiplexed block.
// - vme reads pace at 209 ns single, 156 ns block and multiplexed block.
// - vme writes pace at 180 ns single, 116 ns block, 112 ns multiplexed block.
// - pci master inserts no wait states, irdy held until transaction completes.
// - pci bursts are full and aligned to the aligned burst size where possible.
// - six idle pci clocks after each transaction before requesting again.
// - aligned burst size allows at most 128 bytes per pci burst.
// - with the pci bus parked on us, start without a fresh request.
// - 32-byte bursts reach about 97 and 98 MB/s on a 32-bit pci bus.
// - request pci only with 128 bytes free (reads) or queued (writes).
// - request vme only with 64 bytes free (reads) or queued (writes).
// - aligned burst size selects 32, 64 or 128 bytes.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module dma_bus_tenure_control import tenure_pkg::*; (
	// clock, reset and freeze
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// register bus
	input  wire logic [7:0]          awaddr,
	input  wire logic                awvalid,
	output wire logic                awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output wire logic                wready,
	output logic      [1:0]          bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [7:0]          araddr,
	input  wire logic                arvalid,
	output wire logic                arready,
	output logic      [31:0]         rdata,
	output logic      [1:0]          rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	// dma queue fill level in bytes
	input  wire logic [QLEVEL_W-1:0] queue_level,
	// vme master side
	output wire logic                vme_req,
	input  wire logic                vme_grant,
	input  wire logic                vme_other_req,
	output wire logic                vme_bbsy,
	output logic                     vme_strobe,
	output logic                     vme_addr_cycle,
	output wire logic                vme_write,
	output wire logic [1:0]          vme_width,
	output wire logic                vme_block,
	input  wire logic                vme_ack,
	output wire logic                vme_beat_done,
	// pci slave channel accesses towards vme
	input  wire logic                coupled_access,
	input  wire logic                posted_access,
	input  wire logic                posted_queue_full,
	output wire logic                coupled_retry,
	output wire logic                posted_retry,
	// pci master side
	output wire logic                pci_req_n,
	input  wire logic                pci_gnt_n,
	output wire logic                pci_frame_n,
	output wire logic                pci_irdy_n,
	output wire logic                pci_oe,
	input  wire logic                pci_trdy_n,
	output logic      [31:0]         pci_addr,
	output wire logic                pci_write,
	output wire logic                pci_word_done
);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	// 32, 64 or 128 bytes; the spare code falls back to the largest burst
	function automatic logic [7:0] burst_bytes(input logic [1:0] code);
		case (burst_size_type'(code))
			ABS_32:  return 8'h20;
			ABS_64:  return 8'h40;
			default: return 8'h80;
		endcase
	endfunction : burst_bytes

	logic [31:0]   ctrl_r;
	logic [15:0]   tenure_limit_r, backoff_r, tenure_cnt_r, backoff_cnt_r;
	vme_state_type vme_state_r;
	pci_state_type pci_state_r;
	logic          beat_active_r, first_beat_r;
	logic [4:0]    beat_timer_r;
	logic [5:0]    words_r;
	logic [2:0]    gap_r;

	// ------- control decode
	wire                enable     = ctrl_r[CTRL_ENABLE_BIT];
	wire                release_on_request_policy = ctrl_r[CTRL_POLICY_BIT];
	wire                pci_to_vme = ctrl_r[CTRL_DIR_BIT];
	wire [1:0]          width      = ctrl_r[CTRL_WIDTH_LSB +: 2];
	wire [QLEVEL_W-1:0] free_bytes = QLEVEL_W'(QUEUE_BYTES) - queue_level;
	wire [3:0]          beat_bytes = 4'h1 << width;
	wire                mblt       = vme_block && (width_type'(width) == W_D64);

	assign vme_write = pci_to_vme;
	assign vme_width = width;
	assign vme_block = ctrl_r[CTRL_BLOCK_BIT];
	assign pci_write = !pci_to_vme;

	// pacing depends on direction and mode; width only picks multiplexed block for D64 block writes
	wire [4:0] beat_cycles = vme_write ?
		(mblt ? 5'(VME_WR_MBLT_CYC) : vme_block ? 5'(VME_WR_BLOCK_CYC) : 5'(VME_WR_SINGLE_CYC)) :
		(vme_block ? 5'(VME_RD_BLOCK_CYC) : 5'(VME_RD_SINGLE_CYC));

	wire vme_ok = vme_write ? (queue_level >= QLEVEL_W'(VME_WATERMARK))
		: (free_bytes >= QLEVEL_W'(VME_WATERMARK));
	wire beat_ok = vme_write ? (queue_level >= QLEVEL_W'(beat_bytes))
		: (free_bytes >= QLEVEL_W'(beat_bytes));
	wire pci_ok = pci_write ? (queue_level >= QLEVEL_W'(PCI_WATERMARK))
		: (free_bytes >= QLEVEL_W'(PCI_WATERMARK));

	// ------- vme tenure
	wire owned      = vme_state_r == V_OWN;
	wire expired    = (tenure_limit_r != 16'h0000) && (tenure_cnt_r >= tenure_limit_r);
	wire beat_start = owned && !beat_active_r && beat_timer_r == 5'h00 && enable && beat_ok && !expired;
	wire beat_end   = beat_active_r && vme_ack;
	wire idle_beat  = owned && !beat_active_r;

	assign vme_req       = vme_state_r == V_REQ;
	assign vme_bbsy      = owned;
	assign vme_beat_done = beat_end;
	assign coupled_retry = coupled_access && owned;
	assign posted_retry  = posted_access && posted_queue_full;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vme_state_r   <= V_IDLE;
			tenure_cnt_r  <= 16'h0000;
			backoff_cnt_r <= 16'h0000;
		end else if (ce) begin
			case (vme_state_r)
				V_IDLE: begin
					if (enable && vme_ok) begin
						vme_state_r <= V_REQ;
					end
				end
				V_REQ: begin
					if (vme_grant) begin
						vme_state_r  <= V_OWN;
						tenure_cnt_r <= 16'h0000;
					end
				end
				V_OWN: begin
					if (beat_end) begin
						tenure_cnt_r <= tenure_cnt_r + 16'(beat_bytes);
					end
					if (idle_beat && expired) begin
						vme_state_r   <= V_BACKOFF;
						backoff_cnt_r <= backoff_r;
					end else if (idle_beat && (!enable || (release_on_request_policy ? vme_other_req : !beat_ok))) begin
						vme_state_r <= V_IDLE;
					end
				end
				default: begin
					if (backoff_cnt_r == 16'h0000) begin
						vme_state_r <= V_IDLE;
					end else begin
						backoff_cnt_r <= backoff_cnt_r - 16'h0001;
					end
				end
			endcase
		end
	end

	// beat engine: strobe until acknowledged, next start no sooner than one cycle target
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			beat_active_r  <= 1'b0;
			beat_timer_r   <= 5'h00;
			first_beat_r   <= 1'b1;
			vme_strobe     <= 1'b0;
			vme_addr_cycle <= 1'b0;
		end else if (ce) begin
			if (beat_timer_r != 5'h00) begin
				beat_timer_r <= beat_timer_r - 5'h01;
			end
			if (beat_start) begin
				beat_active_r  <= 1'b1;
				beat_timer_r   <= beat_cycles - 5'h01;
				vme_strobe     <= 1'b1;
				vme_addr_cycle <= first_beat_r || !vme_block;
				first_beat_r   <= 1'b0;
			end else if (beat_end) begin
				beat_active_r  <= 1'b0;
				vme_strobe     <= 1'b0;
				vme_addr_cycle <= 1'b0;
			end
			if (!owned) begin
				first_beat_r <= 1'b1;
			end
		end
	end

	// ------- pci bursts
	wire [7:0]  burst_len = burst_bytes(ctrl_r[CTRL_ABS_LSB +: 2]);
	wire [7:0]  misalign  = pci_addr[7:0] & (burst_len - 8'h01);
	wire [5:0]  words_nxt = 6'((burst_len - misalign) >> 2);
	wire        word_take = pci_state_r == P_DATA && !pci_trdy_n;
	wire        last_take = word_take && words_r == 6'h01;
	wire        pci_start = pci_state_r == P_IDLE && enable && pci_ok;

	assign pci_req_n     = pci_state_r != P_REQ;
	assign pci_frame_n   = !(pci_state_r == P_ADDR || (pci_state_r == P_DATA && words_r != 6'h01));
	assign pci_irdy_n    = pci_state_r != P_DATA;
	assign pci_oe        = pci_state_r == P_ADDR || pci_state_r == P_DATA;
	assign pci_word_done = word_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pci_state_r <= P_IDLE;
			words_r     <= 6'h00;
			gap_r       <= 3'h0;
		end else if (ce) begin
			case (pci_state_r)
				P_IDLE: begin
					if (pci_start) begin
						pci_state_r <= pci_gnt_n ? P_REQ : P_ADDR;
						words_r     <= words_nxt;
					end
				end
				P_REQ: begin
					if (!pci_gnt_n) begin
						pci_state_r <= P_ADDR;
					end
				end
				P_ADDR: pci_state_r <= P_DATA;
				P_DATA: begin
					if (word_take) begin
						words_r <= words_r - 6'h01;
					end
					if (last_take) begin
						pci_state_r <= P_GAP;
						gap_r       <= 3'(PCI_IDLE_GAP - 1);
					end
				end
				default: begin
					if (gap_r == 3'h0) begin
						pci_state_r <= P_IDLE;
					end else begin
						gap_r <= gap_r - 3'h1;
					end
				end
			endcase
		end
	end

	// ------- register bus
	wire wr_take = ce && awvalid && wvalid && !bvalid;
	wire rd_take = ce && arvalid && !rvalid;
	wire aw_map  = awaddr == CTRL_OFFSET || awaddr == TENURE_OFFSET || awaddr == BACKOFF_OFFSET
		|| awaddr == PCI_ADDR_OFFSET;
	wire [31:0] status_word = {24'h000000, 1'b0, pci_state_r, vme_state_r, owned, expired};
	wire [31:0] rd_word;
	wire        rd_map;

	assign awready = wr_take;
	assign wready  = wr_take;
	assign arready = rd_take;
	assign rd_map  = araddr == CTRL_OFFSET || araddr == TENURE_OFFSET || araddr == BACKOFF_OFFSET
		|| araddr == PCI_ADDR_OFFSET || araddr == STATUS_OFFSET || araddr == COUNT_OFFSET;
	assign rd_word = (araddr == CTRL_OFFSET)     ? ctrl_r :
		(araddr == TENURE_OFFSET)   ? {16'h0000, tenure_limit_r} :
		(araddr == BACKOFF_OFFSET)  ? {16'h0000, backoff_r} :
		(araddr == PCI_ADDR_OFFSET) ? pci_addr :
		(araddr == STATUS_OFFSET)   ? status_word :
		(araddr == COUNT_OFFSET)    ? {16'h0000, tenure_cnt_r} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r         <= CTRL_RESET;
			tenure_limit_r <= TENURE_RESET;
			backoff_r      <= BACKOFF_RESET;
			pci_addr       <= 32'h0000_0000;
			bvalid         <= 1'b0;
			bresp          <= RESP_OKAY;
		end else if (ce) begin
			if (word_take) begin
				pci_addr <= pci_addr + 32'(PCI_BUS_BYTES);
			end
			if (wr_take) begin
				bvalid <= 1'b1;
				bresp  <= aw_map ? RESP_OKAY : RESP_SLVERR;
				if (awaddr == CTRL_OFFSET) begin
					ctrl_r <= merge_bytes(ctrl_r, wdata, wstrb);
				end else if (awaddr == TENURE_OFFSET) begin
					tenure_limit_r <= 16'(merge_bytes({16'h0000, tenure_limit_r}, wdata, wstrb));
				end else if (awaddr == BACKOFF_OFFSET) begin
					backoff_r <= 16'(merge_bytes({16'h0000, backoff_r}, wdata, wstrb));
				end else if (awaddr == PCI_ADDR_OFFSET && !pci_oe) begin
					pci_addr <= merge_bytes(pci_addr, wdata, wstrb) & 32'hFFFF_FFFC;
				end
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_take) begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ------- checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	chk_coupled_retry: assert property (owned && coupled_access |-> coupled_retry)
		else $error("coupled access not retried while dma owns vme");
	chk_tenure_expiry: assert property (idle_beat && expired |=> vme_state_r == V_BACKOFF && !vme_bbsy)
		else $error("tenure limit reached but ownership kept");
	chk_backoff_quiet: assert property (vme_state_r == V_BACKOFF && backoff_cnt_r != 16'h0000 |=> !vme_req)
		else $error("vme request raised during back-off");
	chk_tenure_reload: assert property ($rose(owned) |-> tenure_cnt_r == 16'h0000)
		else $error("tenure counter not reloaded at ownership start");
	chk_vme_watermark: assert property ($rose(vme_req) |-> $past(vme_ok) && $past(enable))
		else $error("vme requested below watermark");
	chk_pci_watermark: assert property ($fell(pci_req_n) |-> $past(pci_ok))
		else $error("pci requested below watermark");
	chk_irdy_held: assert property ((pci_state_r == P_ADDR || (pci_state_r == P_DATA && !last_take))
		|=> !pci_irdy_n)
		else $error("irdy dropped inside a transaction");
	chk_idle_gap: assert property (last_take |=> (pci_req_n && pci_frame_n) [*6])
		else $error("pci re-requested within the idle gap");
	chk_parked_start: assert property (pci_start && !pci_gnt_n |=> !pci_frame_n && pci_req_n)
		else $error("parked bus not used directly");
	chk_burst_limit: assert property (pci_state_r == P_ADDR |-> words_r != 6'h00 && words_r <= 6'h20)
		else $error("pci burst longer than 128 bytes");
	chk_request_hold: assert property (idle_beat && release_on_request_policy && enable && !vme_other_req
		&& !expired |=> owned)
		else $error("release-on-request gave up the bus unasked");
	chk_beat_pace: assert property (beat_start |=> !beat_start [*8])
		else $error("vme beats started too close together");

	cov_parked_burst:  cover property (pci_start && !pci_gnt_n);
	cov_backoff_entry: cover property (idle_beat && expired);
	cov_request_release: cover property (idle_beat && release_on_request_policy && vme_other_req && !expired);
	cov_posted_retry:  cover property (posted_retry);

endmodule : dma_bus_tenure_control

// ---- logic/tenure_pkg.sv ----
// constants, field layouts and types shared by the dma bus tenure logic
package tenure_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// least time in ns to whole clock cycles, never below one
	function automatic int cycles_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cycles_min

	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] TENURE_OFFSET   = 8'h04;
	localparam logic [7:0] BACKOFF_OFFSET  = 8'h08;
	localparam logic [7:0] PCI_ADDR_OFFSET = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET   = 8'h10;
	localparam logic [7:0] COUNT_OFFSET    = 8'h14;

	// control field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_POLICY_BIT = 1;
	localparam int CTRL_DIR_BIT    = 2;
	localparam int CTRL_BLOCK_BIT  = 3;
	localparam int CTRL_WIDTH_LSB  = 4;
	localparam int CTRL_ABS_LSB    = 6;

	// values after reset
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0080;
	localparam logic [15:0] TENURE_RESET  = 16'h0100;
	localparam logic [15:0] BACKOFF_RESET = 16'h0010;

	// queue watermarks and sizes, in bytes
	localparam int QLEVEL_W        = 9;
	localparam int QUEUE_BYTES     = 256;
	localparam int PCI_WATERMARK   = 128;
	localparam int VME_WATERMARK   = 64;
	localparam int PCI_BUS_BYTES   = 4;

	// idle pci clocks between dma transactions
	localparam int PCI_IDLE_GAP    = 6;

	// vme beat cycle targets
	localparam int VME_RD_SINGLE_NS = 209;
	localparam int VME_RD_BLOCK_NS  = 156;
	localparam int VME_WR_SINGLE_NS = 180;
	localparam int VME_WR_BLOCK_NS  = 116;
	localparam int VME_WR_MBLT_NS   = 112;
	localparam int VME_RD_SINGLE_CYC = cycles_min(VME_RD_SINGLE_NS);
	localparam int VME_RD_BLOCK_CYC  = cycles_min(VME_RD_BLOCK_NS);
	localparam int VME_WR_SINGLE_CYC = cycles_min(VME_WR_SINGLE_NS);
	localparam int VME_WR_BLOCK_CYC  = cycles_min(VME_WR_BLOCK_NS);
	localparam int VME_WR_MBLT_CYC   = cycles_min(VME_WR_MBLT_NS);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ABS_32, ABS_64, ABS_128} burst_size_type;
	typedef enum logic [1:0] {W_D08, W_D16, W_D32, W_D64} width_type;
	typedef enum logic [1:0] {V_IDLE, V_REQ, V_OWN, V_BACKOFF} vme_state_type;
	typedef enum logic [2:0] {P_IDLE, P_REQ, P_ADDR, P_DATA, P_GAP} pci_state_type;

endpackage : tenure_pkg

// ---- verification/far_side_model.sv ----
// far side model: vme arbiter and slave, pci arbiter and zero-wait target
module far_side_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// behaviour knobs
	input  wire logic       park,
	input  wire logic [3:0] ack_wait,
	// vme side
	input  wire logic       vme_req,
	input  wire logic       vme_bbsy,
	input  wire logic       vme_strobe,
	output logic            vme_grant,
	output logic            vme_ack,
	// pci side
	input  wire logic       pci_req_n,
	input  wire logic       pci_irdy_n,
	output logic            pci_gnt_n,
	output wire logic       pci_trdy_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] wait_r;

	// zero-wait target; trdy is pulled high whenever irdy is released
	assign pci_trdy_n = pci_irdy_n;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vme_grant <= 1'b0;
			vme_ack <= 1'b0;
			wait_r <= 4'h0;
			pci_gnt_n <= 1'b1;
		end else begin
			vme_grant <= vme_req | vme_bbsy;
			// a parked bus keeps the grant with no request at all
			pci_gnt_n <= !(park | !pci_req_n);
			// acknowledge drops once strobe is gone, as a pulled-up line would
			if (!vme_strobe) begin
				wait_r <= 4'h0;
				vme_ack <= 1'b0;
			end else if (wait_r == ack_wait) begin
				vme_ack <= 1'b1;
			end else begin
				wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule : far_side_model

// ---- verification/dma_bus_tenure_control_bench.sv ----
// self-checking bench for the dma bus tenure control block
module dma_bus_tenure_control_bench import tenure_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                aclk = 1'b0;
	logic                aresetn = 1'b0;
	logic                ce = 1'b1;
	logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]         wdata = 32'h0, rd;
	logic [3:0]          wstrb = 4'hF, ack_wait = 4'h0;
	logic                awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1, park = 0;
	logic [QLEVEL_W-1:0] queue_level = '0;
	logic                vme_other_req = 0, coupled_access = 0, posted_access = 0, posted_queue_full = 0;
	logic                strobe_q = 0, frame_q = 1;
	logic [1:0]          resp;
	wire                 awready, wready, bvalid, arready, rvalid, vme_req, vme_grant, vme_bbsy, vme_strobe;
	wire                 vme_ack, vme_write, vme_block, vme_beat_done, coupled_retry, posted_retry;
	wire                 vme_addr_cycle, pci_write;
	wire                 pci_req_n, pci_gnt_n, pci_frame_n, pci_irdy_n, pci_oe, pci_trdy_n, pci_word_done;
	wire [1:0]           bresp, rresp, vme_width;
	wire [31:0]          rdata, pci_addr;
	int                  n_fail = 0, total_checks = 0, cyc = 0, beats = 0, words = 0, irdy_cycles = 0;
	int                  req_cycles = 0, vreq_cycles = 0, last_word = 0, frame_gap = 0, rise_at = 0, rise_gap = 0;
	int                  addr_beats = 0;

	dma_bus_tenure_control dut_u (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .queue_level, .vme_req, .vme_grant, .vme_other_req, .vme_bbsy, .vme_strobe, .vme_addr_cycle,
		.vme_write, .vme_width, .vme_block, .vme_ack, .vme_beat_done, .coupled_access, .posted_access,
		.posted_queue_full, .coupled_retry, .posted_retry, .pci_req_n, .pci_gnt_n, .pci_frame_n, .pci_irdy_n,
		.pci_oe, .pci_trdy_n, .pci_addr, .pci_write, .pci_word_done);

	far_side_model far_u (.aclk, .aresetn, .park, .ack_wait, .vme_req, .vme_bbsy, .vme_strobe, .vme_grant,
		.vme_ack, .pci_req_n, .pci_irdy_n, .pci_gnt_n, .pci_trdy_n);

	always #5 aclk = ~aclk;

	// bus monitor; the 40000 cycle ceiling is far above the whole sequence
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		strobe_q <= vme_strobe;
		frame_q <= pci_frame_n;
		if (vme_strobe && !strobe_q) begin
			rise_gap <= cyc - rise_at;
			rise_at <= cyc;
			if (vme_addr_cycle) addr_beats <= addr_beats + 1;
		end
		if (vme_beat_done) beats <= beats + 1;
		if (pci_word_done) words <= words + 1;
		if (pci_word_done) last_word <= cyc;
		if (!pci_irdy_n) irdy_cycles <= irdy_cycles + 1;
		if (!pci_req_n) req_cycles <= req_cycles + 1;
		if (vme_req) vreq_cycles <= vreq_cycles + 1;
		if (!pci_frame_n && frame_q) frame_gap <= cyc - last_word;
		if (cyc == 40000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// waits end only by the bench timeout, which counts as a mismatch
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		@(posedge aclk);
		while (!(awready && wready)) @(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (!bvalid) @(posedge aclk);
		resp = bresp;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		rd = rdata;
		resp = rresp;
	endtask : axi_read

	task automatic go_idle();
		axi_write(CTRL_OFFSET, 32'h0, 4'hF);
		while (vme_bbsy || vme_req || pci_oe || !pci_req_n) @(posedge aclk);
		repeat (20) @(posedge aclk);
	endtask : go_idle

	task automatic reg_scenario();
		logic [7:0]  offs [6] = '{CTRL_OFFSET, TENURE_OFFSET, BACKOFF_OFFSET, PCI_ADDR_OFFSET, STATUS_OFFSET,
			COUNT_OFFSET};
		logic [31:0] vals [6] = '{CTRL_RESET, {16'h0, TENURE_RESET}, {16'h0, BACKOFF_RESET}, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			axi_read(offs[i]);
			check("reset value", rd, vals[i]);
			check("read response", resp, RESP_OKAY);
		end
		axi_read(8'h18);
		check("unmapped read", resp, RESP_SLVERR);
		axi_write(8'h1C, 32'hFFFF_FFFF, 4'hF);
		check("unmapped write", resp, RESP_SLVERR);
		axi_write(TENURE_OFFSET, 32'h0000_ABCD, 4'h1);
		axi_read(TENURE_OFFSET);
		check("byte lane write", rd, 32'h0000_01CD);
		axi_write(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
		axi_read(STATUS_OFFSET);
		check("status read only", rd, 32'h0);
		// with the clock enable low nothing may be taken
		ce <= 1'b0;
		awaddr <= TENURE_OFFSET;
		wdata <= 32'h0;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		repeat (3) @(posedge aclk);
		check("frozen handshake", awready, 0);
		{awvalid, wvalid, ce} <= 3'b001;
		axi_read(TENURE_OFFSET);
		check("frozen register", rd, 32'h0000_01CD);
	endtask : reg_scenario

	// two tenures of four beats each, with the back-off between them
	task automatic vme_pace(input logic [7:0] ctrl, input int exp_cyc);
		int bytes, b0, a0, k;
		bytes = 1 << ctrl[5:4];
		queue_level <= ctrl[2] ? 9'd200 : 9'd0;
		axi_write(TENURE_OFFSET, 4 * bytes, 4'hF);
		axi_write(BACKOFF_OFFSET, 32'h5, 4'hF);
		axi_write(CTRL_OFFSET, {24'h0, ctrl}, 4'hF);
		for (int t = 0; t < 2; t++) begin
			while (!vme_bbsy) @(posedge aclk);
			b0 = beats;
			a0 = addr_beats;
			check("vme width", vme_width, ctrl[5:4]);
			check("vme block", vme_block, ctrl[3]);
			check("vme direction", vme_write, ctrl[2]);
			while (vme_bbsy) @(posedge aclk);
			check("tenure beats", beats - b0, 4);
			check("address beats", addr_beats - a0, ctrl[3] ? 1 : 4);
			check("beat spacing", rise_gap, exp_cyc);
			for (k = 0; k < 50 && !vme_req; k++) @(posedge aclk);
			check("back-off wait", k >= 5 && k <= 10, 1);
		end
		go_idle();
	endtask : vme_pace

	task automatic request_release();
		int k;
		queue_level <= 9'd200;
		ack_wait <= 4'h3;
		axi_write(TENURE_OFFSET, 32'h0, 4'hF);
		axi_write(CTRL_OFFSET, 32'h2F, 4'hF);
		while (!vme_bbsy) @(posedge aclk);
		repeat (300) @(posedge aclk);
		check("ownership kept", vme_bbsy, 1);
		coupled_access <= 1'b1;
		posted_access <= 1'b1;
		repeat (2) @(posedge aclk);
		check("coupled retry", coupled_retry, 1);
		check("posted passes", posted_retry, 0);
		posted_queue_full <= 1'b1;
		repeat (2) @(posedge aclk);
		check("posted retry", posted_retry, 1);
		vme_other_req <= 1'b1;
		for (k = 0; k < 40 && vme_bbsy; k++) @(posedge aclk);
		@(posedge aclk);
		check("release on request", vme_bbsy, 0);
		check("coupled after release", coupled_retry, 0);
		go_idle();
		{coupled_access, posted_access, posted_queue_full, vme_other_req} <= 4'h0;
		ack_wait <= 4'h0;
	endtask : request_release

	task automatic watermarks();
		int v0, p0;
		queue_level <= 9'd63;
		axi_write(CTRL_OFFSET, 32'h2D, 4'hF);
		v0 = vreq_cycles;
		repeat (60) @(posedge aclk);
		check("vme below mark", vreq_cycles - v0, 0);
		queue_level <= 9'd64;
		repeat (20) @(posedge aclk);
		check("vme at mark", vme_bbsy, 1);
		go_idle();
		queue_level <= 9'd127;
		axi_write(CTRL_OFFSET, 32'h01, 4'hF);
		p0 = req_cycles;
		repeat (60) @(posedge aclk);
		check("pci below mark", req_cycles - p0, 0);
		queue_level <= 9'd128;
		repeat (20) @(posedge aclk);
		check("pci at mark", (req_cycles - p0) > 0, 1);
		go_idle();
	endtask : watermarks

	task automatic pci_burst(input logic [1:0] size, input logic [31:0] addr, input logic parked, input int n);
		int w0, i0, r0;
		park <= parked;
		queue_level <= 9'd200;
		axi_write(PCI_ADDR_OFFSET, addr, 4'hF);
		w0 = words;
		i0 = irdy_cycles;
		r0 = req_cycles;
		axi_write(CTRL_OFFSET, {24'h0, size, 6'h01}, 4'hF);
		while (pci_frame_n) @(posedge aclk);
		while (pci_oe) @(posedge aclk);
		check("burst words", words - w0, n);
		check("pci direction", pci_write, 1);
		check("no wait states", irdy_cycles - i0, n);
		check("burst end address", pci_addr, addr + 4 * n);
		check("arbitration request", (req_cycles - r0) > 0, !parked);
		while (pci_frame_n) @(posedge aclk);
		@(posedge aclk);
		check("idle gap", frame_gap >= 7, 1);
		go_idle();
	endtask : pci_burst

	task automatic final_report();
		if (n_fail == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reg_scenario();
		vme_pace(8'h21, 21);
		vme_pace(8'h19, 16);
		vme_pace(8'h3B, 16);
		vme_pace(8'h05, 18);
		vme_pace(8'h2D, 12);
		vme_pace(8'h3D, 12);
		request_release();
		watermarks();
		pci_burst(2'h0, 32'h0, 1'b1, 8);
		pci_burst(2'h1, 32'h0, 1'b0, 16);
		pci_burst(2'h2, 32'h0, 1'b1, 32);
		pci_burst(2'h3, 32'h0, 1'b0, 32);
		pci_burst(2'h0, 32'h10, 1'b1, 4);
		pci_burst(2'h2, 32'h40, 1'b1, 16);
		final_report();
	end
endmodule : dma_bus_tenure_control_bench
